// File: rtl/psl_pkg.sv
// Shared constants for the script launch control block
package psl_pkg;
    localparam int NUM_CH = 3;
    localparam int ADDR_W = 6;
    localparam int INSTR_W = 16;
    localparam int BUF_DEPTH = 60;
    localparam logic [5:0] ADDR_MAX = 6'h3b;
    localparam logic [5:0] ADDR_FIRST = 6'h00;
    // Host command codes
    localparam logic [7:0] CMD_LAUNCH = 8'h96;
    localparam logic [7:0] CMD_HALT = 8'h97;
    // Launch parameter layout: address above, channel code below
    localparam int PRM_ADDR_LSB = 2;
    localparam int PRM_CH_W = 2;
    // Instruction fields
    localparam int OP_LSB = 13;
    localparam logic [2:0] OP_BRANCH = 3'h5;
    localparam logic [2:0] OP_END = 3'h6;
    localparam int END_DIS_BIT = 11;
    localparam int LOOP_LSB = 7;
    localparam int LOOP_W = 6;
    localparam logic [15:0] INSTR_GOTO_START = 16'h0000;
    localparam logic [5:0] LOOP_ENDLESS = 6'h00;
    localparam logic [5:0] LOOP_ONE = 6'h01;
    // Reset values
    localparam logic [15:0] INSTR_RST = 16'h0000;
    localparam logic [2:0] ATTN_RST = 3'h0;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_RUN = 2'b01,
        SEQ_WAIT = 2'b10
    } psl_seq_e;
endpackage

// File: rtl/psl_ch_if.sv
// Per-channel link between the launch control and one script sequencer
`timescale 1ns/1ps
interface psl_ch_if;
    logic launch;
    logic halt;
    logic [5:0] start_addr;
    logic [5:0] pc;
    logic [15:0] instr;
    logic end_evt;
    logic out_en;
    logic exec_valid;
    logic [15:0] exec_instr;
    logic exec_done;
    logic exec_abort;

    modport ctrl (
        output launch, halt, start_addr, instr, exec_done,
        input pc, end_evt, out_en, exec_valid, exec_instr, exec_abort
    );
    modport seq (
        input launch, halt, start_addr, instr, exec_done,
        output pc, end_evt, out_en, exec_valid, exec_instr, exec_abort
    );
endinterface

// File: rtl/psl_seq.sv
// Script sequencer for one pulse channel
`timescale 1ns/1ps
module psl_seq (
    input wire logic clk_i,
    input wire logic rstn_i,
    psl_ch_if.seq ch
);
    typedef struct packed {
        psl_pkg::psl_seq_e st;
        logic [5:0] pc;
        logic [5:0] start;
        logic loop_act;
        logic [5:0] loop_cnt;
        logic out_en;
        logic end_evt;
        logic [15:0] ins;
    } psl_seq_s;

    psl_seq_s s_q, s_d;
    logic [2:0] op;
    logic [5:0] lc;
    logic [5:0] dst;

    // Decode of the instruction at the program counter
    assign op = ch.instr[psl_pkg::OP_LSB +: 3];
    assign lc = ch.instr[psl_pkg::LOOP_LSB +: psl_pkg::LOOP_W];
    assign dst = ch.instr[psl_pkg::ADDR_W-1:0];

    // Next state of the sequencer
    always_comb begin
        s_d = s_q;
        s_d.end_evt = 1'b0;
        unique case (s_q.st)
            psl_pkg::SEQ_IDLE: begin
            end
            psl_pkg::SEQ_RUN: begin
                if (op == psl_pkg::OP_END) begin
                    s_d.out_en = ~ch.instr[psl_pkg::END_DIS_BIT]; // [R04] [R05]
                    s_d.end_evt = 1'b1; // [R11]
                    s_d.st = psl_pkg::SEQ_IDLE;
                end else if (op == psl_pkg::OP_BRANCH) begin
                    if (dst > psl_pkg::ADDR_MAX) begin
                        s_d.st = (s_q.pc == psl_pkg::ADDR_MAX) ? psl_pkg::SEQ_IDLE
                                                              : psl_pkg::SEQ_RUN; // [R10]
                        s_d.pc = s_q.pc + 6'h01;
                    end else if (lc == psl_pkg::LOOP_ENDLESS) begin
                        s_d.pc = dst; // [R03]
                    end else if (!s_q.loop_act && lc != psl_pkg::LOOP_ONE) begin
                        s_d.loop_act = 1'b1;
                        s_d.loop_cnt = lc - 6'h02; // Count is biased by two
                        s_d.pc = dst; // [R03]
                    end else if (s_q.loop_act && s_q.loop_cnt != 6'h00) begin
                        s_d.loop_cnt = s_q.loop_cnt - 6'h01;
                        s_d.pc = dst;
                    end else begin
                        // Loop used up: fall through to the next address
                        s_d.loop_act = 1'b0;
                        s_d.pc = s_q.pc + 6'h01; // [R09]
                        if (s_q.pc == psl_pkg::ADDR_MAX) begin
                            s_d.st = psl_pkg::SEQ_IDLE;
                        end
                    end
                end else if (ch.instr == psl_pkg::INSTR_GOTO_START) begin
                    s_d.pc = s_q.start;
                end else begin
                    s_d.ins = ch.instr; // Handed to the step engine
                    s_d.st = psl_pkg::SEQ_WAIT;
                end
            end
            psl_pkg::SEQ_WAIT: begin
                if (ch.exec_done) begin
                    s_d.pc = s_q.pc + 6'h01;
                    s_d.st = (s_q.pc == psl_pkg::ADDR_MAX) ? psl_pkg::SEQ_IDLE
                                                          : psl_pkg::SEQ_RUN;
                end
            end
            default: begin
                s_d.st = psl_pkg::SEQ_IDLE;
            end
        endcase
        // Host commands override the running script
        if (ch.halt) begin
            s_d.st = psl_pkg::SEQ_IDLE; // [R07]
            s_d.loop_act = 1'b0;
        end
        if (ch.launch) begin
            s_d.st = psl_pkg::SEQ_RUN; // [R01]
            s_d.pc = ch.start_addr;
            s_d.start = ch.start_addr;
            s_d.loop_act = 1'b0;
            s_d.out_en = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_q <= '{st: psl_pkg::SEQ_IDLE, pc: psl_pkg::ADDR_FIRST,
                     start: psl_pkg::ADDR_FIRST, loop_act: 1'b0, loop_cnt: 6'h00,
                     out_en: 1'b0, end_evt: 1'b0, ins: psl_pkg::INSTR_RST};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs toward the control and the step engine
    assign ch.pc = s_q.pc;
    assign ch.end_evt = s_q.end_evt;
    assign ch.out_en = s_q.out_en;
    assign ch.exec_valid = (s_q.st == psl_pkg::SEQ_WAIT);
    assign ch.exec_instr = s_q.ins;
    assign ch.exec_abort = (ch.halt || ch.launch) && (s_q.st == psl_pkg::SEQ_WAIT);
endmodule

// File: rtl/psl_top.sv
// Script buffer, launch and halt decoding and attention output for three channels
// Notes on behaviour
// (R01) Buffer holds many scripts; launch starts at address
// (R02) Parameter byte: address high, 2-bit channel low
// (R03) Branch targets are absolute buffer addresses
// (R04) End with disable clear keeps output active
// (R05) End with disable set turns output off
// (R06) Host stops fixed duty via disabling end script
// (R07) Halt with parameter 0x01 stops channel zero
// (R08) Host builds fixed duty with three instructions
// (R09) Spent loop continues at next sequential address
// (R10) Addresses 0 to 59; farther branch never loops
// (R11) End stops script and asserts attention low
`timescale 1ns/1ps
module psl_top (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic buf_we_i,
    input wire logic [5:0] buf_addr_i,
    input wire logic [15:0] buf_data_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [7:0] cmd_param_i,
    input wire logic attn_ack_i,
    input wire logic [2:0] exec_done_i,
    output logic [2:0] exec_valid_o,
    output logic [2:0][15:0] exec_instr_o,
    output logic [2:0] exec_abort_o,
    output logic [2:0] out_en_o,
    output logic [2:0] end_flag_o,
    output logic attn_n_o
);
    typedef struct packed {
        logic [psl_pkg::BUF_DEPTH-1:0][15:0] mem;
        logic [2:0] attn;
    } psl_top_s;

    psl_top_s s_q, s_d;
    logic [5:0] prm_addr;
    logic [1:0] prm_ch;
    logic [2:0] ch_hit;
    logic [2:0] end_evt;

    psl_ch_if ch [psl_pkg::NUM_CH] ();

    // Split of the parameter byte into address and channel code
    assign prm_addr = cmd_param_i[7:psl_pkg::PRM_ADDR_LSB]; // [R02]
    assign prm_ch = cmd_param_i[psl_pkg::PRM_CH_W-1:0]; // [R02]

    // Channel code 1..3 selects channel 0..2; code 0 selects none
    always_comb begin
        ch_hit = 3'h0;
        unique case (prm_ch)
            2'h1: ch_hit = 3'h1; // [R07]
            2'h2: ch_hit = 3'h2;
            2'h3: ch_hit = 3'h4;
            default: ch_hit = 3'h0;
        endcase
    end

    // One sequencer per channel, all sharing the buffer
    for (genvar i = 0; i < psl_pkg::NUM_CH; i++) begin : g_ch
        assign ch[i].launch = cmd_valid_i && (cmd_code_i == psl_pkg::CMD_LAUNCH) &&
                              ch_hit[i] && (prm_addr <= psl_pkg::ADDR_MAX); // [R01] [R06]
        assign ch[i].halt = cmd_valid_i && (cmd_code_i == psl_pkg::CMD_HALT) &&
                            ch_hit[i]; // [R07]
        assign ch[i].start_addr = prm_addr;
        assign ch[i].instr = (ch[i].pc <= psl_pkg::ADDR_MAX) ? s_q.mem[ch[i].pc]
                                                             : psl_pkg::INSTR_RST;
        assign ch[i].exec_done = exec_done_i[i];
        assign exec_valid_o[i] = ch[i].exec_valid;
        assign exec_instr_o[i] = ch[i].exec_instr;
        assign exec_abort_o[i] = ch[i].exec_abort;
        assign out_en_o[i] = ch[i].out_en;
        assign end_evt[i] = ch[i].end_evt;

        psl_seq u_seq (
            .clk_i(clk_i),
            .rstn_i(rstn_i),
            .ch(ch[i])
        );
    end

    // Buffer writes and sticky end flags; a new end beats the acknowledge
    always_comb begin
        s_d = s_q;
        if (buf_we_i && buf_addr_i <= psl_pkg::ADDR_MAX) begin
            s_d.mem[buf_addr_i] = buf_data_i; // [R10]
        end
        if (attn_ack_i) begin
            s_d.attn = psl_pkg::ATTN_RST;
        end
        s_d.attn = s_d.attn | end_evt; // [R11]
    end

    // Buffer content is kept through reset release; flags are cleared
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_q.mem <= s_q.mem;
            s_q.attn <= psl_pkg::ATTN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign end_flag_o = s_q.attn;
    assign attn_n_o = ~(|s_q.attn); // [R11]
endmodule

// File: tb/psl_engine_model.sv
// Step engine stand-in answering offered instructions
`timescale 1ns/1ps
module psl_engine_model #(parameter int DLY = 6) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [2:0] valid_i,
    input wire logic [2:0] abort_i,
    output logic [2:0] done_o,
    output logic [2:0][7:0] steps_o
);
    logic [2:0][7:0] cnt_q;
    // Finish after DLY cycles, drop the offer on abort
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 3; i++) begin
            done_o[i] <= 1'b0;
            if (!rstn_i) begin
                cnt_q[i] <= 8'h00;
                steps_o[i] <= 8'h00;
            end else if (abort_i[i] || !valid_i[i] || done_o[i]) begin
                cnt_q[i] <= 8'h00;
            end else if (cnt_q[i] == 8'(DLY - 1)) begin
                done_o[i] <= 1'b1;
                steps_o[i] <= steps_o[i] + 8'h01;
                cnt_q[i] <= 8'h00;
            end else begin
                cnt_q[i] <= cnt_q[i] + 8'h01;
            end
        end
    end
endmodule

// File: tb/psl_top_assertions.sv
// Port checks for the script launch control
`timescale 1ns/1ps
module psl_top_assertions (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [7:0] cmd_param_i,
    input wire logic attn_ack_i,
    input wire logic [2:0] exec_valid_o,
    input wire logic [2:0] exec_abort_o,
    input wire logic [2:0] out_en_o,
    input wire logic [2:0] end_flag_o,
    input wire logic attn_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Command shapes
    sequence s_halt0;
        cmd_valid_i && cmd_code_i == psl_pkg::CMD_HALT && cmd_param_i == 8'h01;
    endsequence
    sequence s_go(logic [1:0] c);
        cmd_valid_i && cmd_code_i == psl_pkg::CMD_LAUNCH && cmd_param_i[1:0] == c
            && cmd_param_i[7:2] <= psl_pkg::ADDR_MAX;
    endsequence
    chk_attn_level: assert property (attn_n_o == !(|end_flag_o))
        else $error("attention level wrong");
    chk_ack_clear: assert property (attn_ack_i |=> (end_flag_o & $past(end_flag_o)) == 3'h0)
        else $error("flag survived ack");
    chk_launch_ch0: assert property (s_go(2'b01) |=> out_en_o[0])
        else $error("ch0 launch not running");
    chk_launch_ch2: assert property (s_go(2'b11) |=> out_en_o[2])
        else $error("ch2 launch not running");
    chk_halt_stop: assert property (s_halt0 |=> !exec_valid_o[0] [*3])
        else $error("halt did not stop");
    chk_halt_abort: assert property (s_halt0 and exec_valid_o[0] |-> exec_abort_o[0])
        else $error("no abort on halt");
    chk_halt_keep: assert property (s_halt0 and exec_valid_o[0] |=> $stable(out_en_o[0]))
        else $error("halt changed output");
    chk_off_by_end: assert property ($fell(out_en_o[0]) |=> end_flag_o[0])
        else $error("output off without end");
endmodule
bind psl_top psl_top_assertions chk_inst (.clk_i, .rstn_i, .cmd_valid_i, .cmd_code_i,
    .cmd_param_i, .attn_ack_i, .exec_valid_o, .exec_abort_o, .out_en_o, .end_flag_o, .attn_n_o);

// File: tb/tb_top.sv
// Self-checking bench for the script launch control
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0, rstn_i = 1'b0, buf_we_i = 1'b0, cmd_valid_i = 1'b0, attn_ack_i = 1'b0;
    logic [5:0] buf_addr_i = 6'h00;
    logic [15:0] buf_data_i = 16'h0000;
    logic [7:0] cmd_code_i = 8'h00, cmd_param_i = 8'h00;
    logic [2:0] exec_done_i, exec_valid_o, exec_abort_o, out_en_o, end_flag_o;
    logic [2:0][15:0] exec_instr_o;
    logic [2:0][7:0] st;
    logic attn_n_o;
    int n_fail = 0;
    int cmp_count = 0;
    psl_top psl_top_inst (.clk_i, .rstn_i, .buf_we_i, .buf_addr_i, .buf_data_i, .cmd_valid_i,
        .cmd_code_i, .cmd_param_i, .attn_ack_i, .exec_done_i, .exec_valid_o, .exec_instr_o,
        .exec_abort_o, .out_en_o, .end_flag_o, .attn_n_o);
    psl_engine_model psl_engine_model_inst (.clk_i, .rstn_i, .valid_i(exec_valid_o),
        .abort_i(exec_abort_o), .done_o(exec_done_i), .steps_o(st));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_i);
        buf_we_i <= 1'b1;
        buf_addr_i <= a;
        buf_data_i <= d;
        @(posedge clk_i);
        buf_we_i <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] p);
        @(posedge clk_i);
        cmd_valid_i <= 1'b1;
        cmd_code_i <= c;
        cmd_param_i <= p;
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
    endtask
    // Wait for a channel end, then acknowledge it
    task automatic end_ack(input int ch);
        for (int k = 0; k < 400 && end_flag_o[ch] !== 1'b1; k++) begin
            @(posedge clk_i);
            #1;
        end
        chk(16'(end_flag_o[ch]), 16'h0001);
        if (end_flag_o[ch] !== 1'b1) close_out();
        chk(16'(attn_n_o), 16'h0000);
        @(posedge clk_i);
        attn_ack_i <= 1'b1;
        @(posedge clk_i);
        attn_ack_i <= 1'b0;
        #1;
        chk(16'(attn_n_o), 16'h0001);
    endtask
    // Fixed duty: set, ramp, then end with the output kept
    task automatic t_keep();
        wr(6'h00, 16'h4000);
        wr(6'h01, 16'h0f33);
        wr(6'h02, 16'hc000);
        cmd(psl_pkg::CMD_LAUNCH, 8'h01);
        end_ack(0);
        chk(16'(out_en_o[0]), 16'h0001);
        chk(16'(st[0]), 16'h0002);
    endtask
    task automatic t_off();
        wr(6'h0c, 16'hc800);
        cmd(psl_pkg::CMD_LAUNCH, 8'h31);
        end_ack(0);
        chk(16'(out_en_o[0]), 16'h0000);
    endtask
    task automatic t_loop();
        wr(6'h10, 16'h4000);
        wr(6'h11, 16'ha190);
        wr(6'h12, 16'hc000);
        cmd(psl_pkg::CMD_LAUNCH, 8'h43);
        end_ack(2);
        chk(16'(st[2]), 16'h0003);
        chk(16'(out_en_o[2]), 16'h0001);
    endtask
    task automatic t_far();
        wr(6'h20, 16'ha03f);
        wr(6'h21, 16'hc800);
        cmd(psl_pkg::CMD_LAUNCH, 8'h82);
        end_ack(1);
        chk(16'(st[1]), 16'h0000);
        chk(16'(out_en_o[1]), 16'h0000);
    endtask
    // Endless loop on channel zero, halted while the engine is busy
    task automatic t_halt();
        wr(6'h18, 16'h4000);
        wr(6'h19, 16'ha018);
        cmd(psl_pkg::CMD_LAUNCH, 8'h61);
        repeat (20) @(posedge clk_i);
        #1;
        // Catch the start of an engine offer so the halt lands inside it
        for (int k = 0; k < 50 && exec_valid_o[0] !== 1'b0; k++) begin
            @(posedge clk_i);
            #1;
        end
        for (int k = 0; k < 50 && exec_valid_o[0] !== 1'b1; k++) begin
            @(posedge clk_i);
            #1;
        end
        chk(16'(exec_valid_o[0]), 16'h0001);
        if (exec_valid_o[0] !== 1'b1) close_out();
        chk(exec_instr_o[0], 16'h4000);
        cmd(psl_pkg::CMD_HALT, 8'h01);
        repeat (3) @(posedge clk_i);
        #1;
        chk(16'(exec_valid_o[0]), 16'h0000);
        chk(16'(end_flag_o), 16'h0000);
        chk(16'(out_en_o[0]), 16'h0001);
        cmd(psl_pkg::CMD_LAUNCH, 8'h31);
        end_ack(0);
        chk(16'(out_en_o[0]), 16'h0000);
    endtask
    // Clock at 20 MHz
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // Reset, then scenarios in turn
    initial begin
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_keep();
        t_off();
        t_loop();
        t_far();
        t_halt();
        close_out();
    end
endmodule
